// ===== shared/flash_ctrl_pkg.sv
// Package for the self-programming flash controller: offsets, fields, timing.
// Assumes a 125 MHz core clock and an AXI4-Lite register bus.
package flash_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
    localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
    localparam logic [7:0] DATA_LOW_OFS = 8'h08;
    localparam logic [7:0] DATA_HIGH_OFS = 8'h0C;
    localparam logic [7:0] CONTROL_OFS = 8'h10;
    localparam logic [7:0] KEY_OFS = 8'h14;
    localparam logic [7:0] CONFIG_OFS = 8'h18;
    localparam logic [7:0] STALL_OFS = 8'h1C;
    // Control register bit positions
    localparam int READ_BIT = 0;
    localparam int PROG_BIT = 1;
    localparam int PERMIT_BIT = 2;
    localparam int ABORT_BIT = 3;
    localparam int LATCH_ONLY_BIT = 5;
    localparam int ERASE_BIT = 4;
    localparam int CFG_SEL_BIT = 6;
    // Geometry
    localparam int WORD_W = 14;
    localparam int ADDR_W = 15;
    localparam int LATCH_N = 16;
    localparam int MEM_WORDS = 16384;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;
    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int READ_SLOT_CYCLES = 2;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    typedef struct packed {
        logic read_start;
        logic prog_start;
        logic permit;
        logic abort;
        logic erase;
        logic latch_only;
        logic cfg_sel;
    } control_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_PROG = 4'b1000
    } state_t;
endpackage

// ===== core/flash_self_program_ctrl.sv
// Self-programming flash controller with AXI4-Lite register access.
// Assumes a synchronous core clock; config straps and reset cause come from pins.
`timescale 1ns/1ns
module flash_self_program_ctrl #(
    parameter int PROG_CYCLES_P = flash_ctrl_pkg::PROG_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic abort_reset_in,
    input wire logic code_protect_n_in,
    input wire logic [1:0] self_program_lock_in,
    input wire logic bulk_erase_in,
    input wire logic ext_read_req_in,
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] ext_addr_in,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic cpu_stall_out,
    output logic [flash_ctrl_pkg::WORD_W-1:0] ext_read_data_out
);
    import flash_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] addr_low_reg, addr_high_reg, data_low_reg, data_high_reg;
    control_t ctl_reg;
    state_t state_reg;
    logic [31:0] cnt_reg;
    logic [1:0] key_stage_reg;
    logic [WORD_W-1:0] mem [MEM_WORDS];
    logic [WORD_W-1:0] latch_reg [LATCH_N];
    logic [1:0] abort_sync_reg;
    logic [1:0] cp_sync_reg;
    logic [1:0] ext_req_sync_reg;
    logic [1:0] bulk_sync_reg;
    logic [1:0] lock_meta_reg, lock_sync_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_have_reg, w_have_reg;
    logic bulk_prev_reg;

    // Synchronize abort, protect, read request, bulk erase and lock pins through two flops each
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            abort_sync_reg <= 2'h0;
            cp_sync_reg <= 2'h3;
            ext_req_sync_reg <= 2'h0;
            bulk_sync_reg <= 2'h0;
            lock_meta_reg <= LOCK_RESET;
            lock_sync_reg <= LOCK_RESET;
        end else begin
            abort_sync_reg <= {abort_sync_reg[0], abort_reset_in};
            cp_sync_reg <= {cp_sync_reg[0], code_protect_n_in};
            ext_req_sync_reg <= {ext_req_sync_reg[0], ext_read_req_in};
            bulk_sync_reg <= {bulk_sync_reg[0], bulk_erase_in};
            lock_meta_reg <= self_program_lock_in;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel; address and data accepted in either order
    logic wr_fire;
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= awaddr[7:0];
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= (aw_addr_reg > STALL_OFS || aw_addr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    logic wr_en;
    assign wr_en = wr_fire && w_strb_reg[0];
    logic key_wr, prog_set, read_set;
    assign key_wr = wr_en && aw_addr_reg == KEY_OFS;
    assign prog_set = wr_en && aw_addr_reg == CONTROL_OFS && w_data_reg[PROG_BIT];
    assign read_set = wr_en && aw_addr_reg == CONTROL_OFS && w_data_reg[READ_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Unlock tracker: any other bus write between steps breaks the sequence
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            key_stage_reg <= 2'h0;
        end else if (wr_fire) begin
            if (key_wr && w_data_reg[7:0] == KEY_FIRST) begin
                key_stage_reg <= 2'h1;
            end else if (key_wr && w_data_reg[7:0] == KEY_SECOND && key_stage_reg == 2'h1) begin
                key_stage_reg <= 2'h2;
            end else begin
                key_stage_reg <= 2'h0;
            end
        end
    end

    logic unlocked_go;
    assign unlocked_go = prog_set && key_stage_reg == 2'h2 && ctl_reg.permit;

    // Lock field: 11 none, 10 lower quarter, 01 lower half, 00 all
    logic [ADDR_W-1:0] flash_addr;
    assign flash_addr = {addr_high_reg[6:0], addr_low_reg};
    logic locked;
    always_comb begin
        case (lock_sync_reg)
            2'h3: locked = 1'b0;
            2'h2: locked = flash_addr[13:12] == 2'h0;
            2'h1: locked = !flash_addr[13];
            default: locked = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 32'h0000_0000;
                    if (read_set && state_reg == ST_IDLE) begin
                        state_reg <= ST_READ;
                    end else if (unlocked_go && (ctl_reg.latch_only || !locked)) begin
                        state_reg <= ctl_reg.latch_only ? ST_LOAD : ST_PROG;
                    end
                end
                ST_READ: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg == 32'(READ_SLOT_CYCLES - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_LOAD: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg == 32'(READ_SLOT_CYCLES - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg == 32'(PROG_CYCLES_P - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    logic op_done;
    assign op_done = state_reg != ST_IDLE && state_reg != ST_PROG
        ? cnt_reg == 32'(READ_SLOT_CYCLES - 1)
        : state_reg == ST_PROG && cnt_reg == 32'(PROG_CYCLES_P - 1);

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cpu_stall_out <= 1'b0;
        end else begin
            cpu_stall_out <= state_reg == ST_PROG && !op_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_reg <= control_t'(CONTROL_RESET[6:0]);
        end else begin
            if (wr_en && aw_addr_reg == CONTROL_OFS) begin
                ctl_reg.permit <= w_data_reg[PERMIT_BIT];
                ctl_reg.erase <= w_data_reg[ERASE_BIT];
                ctl_reg.latch_only <= w_data_reg[LATCH_ONLY_BIT];
                ctl_reg.cfg_sel <= w_data_reg[CFG_SEL_BIT];
                if (!w_data_reg[ABORT_BIT]) begin
                    ctl_reg.abort <= 1'b0;
                end
            end
            if (read_set && state_reg == ST_IDLE) begin
                ctl_reg.read_start <= 1'b1;
            end else if (state_reg == ST_READ && op_done) begin
                ctl_reg.read_start <= 1'b0;
            end
            if (unlocked_go && state_reg == ST_IDLE) begin
                ctl_reg.prog_start <= 1'b1;
            end else if ((state_reg == ST_PROG || state_reg == ST_LOAD) && op_done) begin
                ctl_reg.prog_start <= 1'b0;
            end
            // Set wins over a same-cycle clear
            if (abort_sync_reg[1] && state_reg == ST_PROG) begin
                ctl_reg.abort <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and data registers, flash array, write latches
    logic read_access;
    assign read_access = state_reg == ST_READ && op_done;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            addr_low_reg <= 8'h00;
            addr_high_reg <= 8'h00;
            data_low_reg <= 8'h00;
            data_high_reg <= 8'h00;
        end else begin
            if (wr_en && aw_addr_reg == ADDR_LOW_OFS) addr_low_reg <= w_data_reg[7:0];
            if (wr_en && aw_addr_reg == ADDR_HIGH_OFS) addr_high_reg <= {1'b0, w_data_reg[6:0]};
            if (read_access) begin
                data_low_reg <= mem[flash_addr[13:0]][7:0];
                data_high_reg <= {2'h0, mem[flash_addr[13:0]][13:8]};
            end else begin
                if (wr_en && aw_addr_reg == DATA_LOW_OFS) data_low_reg <= w_data_reg[7:0];
                if (wr_en && aw_addr_reg == DATA_HIGH_OFS) begin
                    data_high_reg <= {2'h0, w_data_reg[5:0]};
                end
            end
        end
    end

    logic prog_end;
    assign prog_end = state_reg == ST_PROG && op_done;

    genvar gi;
    generate
        for (gi = 0; gi < LATCH_N; gi++) begin : g_latch
            always_ff @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    latch_reg[gi] <= ERASED_WORD;
                end else if (prog_end) begin
                    latch_reg[gi] <= ERASED_WORD;
                end else if (state_reg == ST_LOAD && op_done && flash_addr[3:0] == 4'(gi)) begin
                    latch_reg[gi] <= {data_high_reg[5:0], data_low_reg};
                end
            end
        end
    endgenerate

    // Array has no reset; contents survive a core reset like real flash
    always_ff @(posedge core_clk_in) begin
        if (bulk_sync_reg[1] && !bulk_prev_reg) begin
            for (int i = 0; i < MEM_WORDS; i++) mem[i] <= ERASED_WORD;
        end else if (prog_end) begin
            for (int i = 0; i < LATCH_N; i++) begin
                if (ctl_reg.erase) begin
                    mem[{flash_addr[13:4], 4'(i)}] <= ERASED_WORD;
                end else begin
                    mem[{flash_addr[13:4], 4'(i)}] <= latch_reg[i];
                end
            end
        end
    end

    // External programmer read port, blocked by code protection
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bulk_prev_reg <= 1'b0;
            ext_read_data_out <= 14'h0000;
        end else begin
            bulk_prev_reg <= bulk_sync_reg[1];
            // Protection also hides a word fetched before it came on
            if (!cp_sync_reg[1]) begin
                ext_read_data_out <= 14'h0000;
            end else if (ext_req_sync_reg[1]) begin
                ext_read_data_out <= mem[ext_addr_in[13:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= 2'h0;
                case (araddr[7:0])
                    ADDR_LOW_OFS: rdata <= {24'h0, addr_low_reg};
                    ADDR_HIGH_OFS: rdata <= {24'h0, addr_high_reg};
                    DATA_LOW_OFS: rdata <= {24'h0, data_low_reg};
                    DATA_HIGH_OFS: rdata <= {24'h0, data_high_reg};
                    CONTROL_OFS: rdata <= {25'h0, ctl_reg.cfg_sel, ctl_reg.latch_only,
                        ctl_reg.erase, ctl_reg.abort, ctl_reg.permit,
                        ctl_reg.prog_start, ctl_reg.read_start};
                    KEY_OFS: rdata <= 32'h0000_0000;
                    CONFIG_OFS: rdata <= {29'h0, lock_sync_reg, cp_sync_reg[1]};
                    STALL_OFS: rdata <= {28'h0, state_reg};
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= 2'h2;
                    end
                endcase
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// ===== tb/flash_ctrl_properties.sv
// Concurrent checks on the flash controller ports.
// Bound into every flash_self_program_ctrl; sees only its ports.
`timescale 1ns/1ns
module flash_ctrl_checker #(
    parameter int PROG_CYCLES_P = 20
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic code_protect_n_in,
    input wire logic [1:0] self_program_lock_in,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] araddr,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic cpu_stall_out,
    input wire logic [flash_ctrl_pkg::WORD_W-1:0] ext_read_data_out
);
    import flash_ctrl_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic [31:0] aw_reg;
    logic [31:0] wd_reg;
    logic permit_reg;
    int stall_cnt_reg;
    ////////////////////////////////////////////////////////////////
    // Permit shadow only moves once a control write has completed
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_reg <= 32'h0;
            wd_reg <= 32'h0;
            permit_reg <= 1'b0;
        end else begin
            if (awvalid && awready) aw_reg <= awaddr;
            if (wvalid && wready) wd_reg <= wdata;
            if (bvalid && bready && aw_reg == {24'h0, CONTROL_OFS}) begin
                permit_reg <= wd_reg[PERMIT_BIT];
            end
        end
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stall_cnt_reg <= 0;
        end else begin
            stall_cnt_reg <= cpu_stall_out ? stall_cnt_reg + 1 : 0;
        end
    end
    key_reads_zero_a:
    assert property (arvalid && arready && araddr == {24'h0, KEY_OFS} |=> rvalid && rdata == 32'h0)
        else $error("key register read not zero");
    data_high_width_a:
    assert property (arvalid && arready && araddr == {24'h0, DATA_HIGH_OFS}
        |=> rdata[31:6] == 26'h0)
        else $error("data high wider than the word");
    addr_high_width_a:
    assert property (arvalid && arready && araddr == {24'h0, ADDR_HIGH_OFS}
        |=> rdata[31:7] == 25'h0)
        else $error("address high wider than the address");
    protect_blocks_a:
    // Pin passes two sync flops and the output flop before it shows
    assert property (!code_protect_n_in |-> ##3 ext_read_data_out == 14'h0)
        else $error("protected array visible to programmer");
    stall_bound_a:
    assert property (stall_cnt_reg <= PROG_CYCLES_P + 1) else $error("stall too long");
    stall_length_a:
    assert property ($fell(cpu_stall_out) |-> stall_cnt_reg >= PROG_CYCLES_P - 1)
        else $error("stall too short");
    permit_needed_a:
    assert property ($rose(cpu_stall_out) |-> permit_reg) else $error("program without permit");
    lock_blocks_a:
    assert property ($rose(cpu_stall_out) |-> $past(self_program_lock_in) != 2'h0)
        else $error("program while fully locked");
    cover property ($rose(cpu_stall_out));
    cover property ($fell(cpu_stall_out));
    cover property (!code_protect_n_in ##1 !code_protect_n_in);
endmodule
bind flash_self_program_ctrl flash_ctrl_checker #(.PROG_CYCLES_P(PROG_CYCLES_P))
    i_flash_ctrl_checker (
    .core_clk_in, .reset_in, .code_protect_n_in, .self_program_lock_in, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid,
    .rdata, .cpu_stall_out, .ext_read_data_out);

// ===== tb/cpu_core_model.sv
// Processor core running self-programming firmware over the register bus.
// Bus tasks are called by the bench; hung_out flags a bus that never answers.
`timescale 1ns/1ns
module cpu_core_model (
    input wire logic core_clk_in,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    output logic arvalid,
    input wire logic arready,
    output logic [31:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    output logic hung_out
);
    import flash_ctrl_pkg::*;
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, hung_out} = 6'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge core_clk_in);
        awaddr <= {24'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge core_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 200) hung_out <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        @(posedge core_clk_in);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge core_clk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 200) hung_out <= 1'b1;
    endtask
    task automatic set_addr(input logic [14:0] a);
        wr(ADDR_LOW_OFS, {24'h0, a[7:0]});
        wr(ADDR_HIGH_OFS, {25'h0, a[14:8]});
    endtask
    // Three writes back to back; any other bus write between spoils the key
    task automatic unlock(input logic [31:0] c);
        wr(KEY_OFS, {24'h0, KEY_FIRST});
        wr(KEY_OFS, {24'h0, KEY_SECOND});
        wr(CONTROL_OFS, c | (32'h1 << PROG_BIT));
    endtask
    task automatic start_read(input logic [31:0] c);
        wr(CONTROL_OFS, (c & ~(32'h1 << CFG_SEL_BIT)) | (32'h1 << READ_BIT));
        repeat (2) @(posedge core_clk_in);
    endtask
endmodule

// ===== tb/flash_self_program_ctrl_test.sv
// Self-checking bench for the flash controller with a word-level array model.
// Needs flash_ctrl_pkg, the design, cpu_core_model and the bound checker.
`timescale 1ns/1ns
module flash_self_program_ctrl_test;
    import flash_ctrl_pkg::*;
    localparam int P = 20;
    localparam logic [31:0] PRM = 32'h1 << PERMIT_BIT;
    localparam logic [31:0] ERS = 32'h1 << ERASE_BIT;
    localparam logic [31:0] LWL = 32'h1 << LATCH_ONLY_BIT;
    logic core_clk_in, reset_in, abort_reset_in, code_protect_n_in, bulk_erase_in;
    logic ext_read_req_in, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cpu_stall_out, hung_out;
    logic [1:0] self_program_lock_in, bresp, rresp, r;
    logic [3:0] wstrb;
    logic [14:0] ext_addr_in;
    logic [13:0] ext_read_data_out, v;
    logic [13:0] lat [16];
    logic [13:0] mem [int];
    logic [31:0] awaddr, wdata, araddr, rdata, d, perm;
    int n_errors, total_checks, seed, row, i, k;
    flash_self_program_ctrl #(.PROG_CYCLES_P(P)) i_flash_self_program_ctrl (
        .core_clk_in, .reset_in, .abort_reset_in, .code_protect_n_in, .self_program_lock_in,
        .bulk_erase_in, .ext_read_req_in, .ext_addr_in, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .cpu_stall_out, .ext_read_data_out);
    cpu_core_model i_cpu_core_model (
        .core_clk_in, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .hung_out);
    initial core_clk_in = 1'b0;
    always #4 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (hung_out === 1'b1) fail_now();
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic fail_now();
        n_errors++;
        give_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        i_cpu_core_model.rd(a, d, r);
        chk(d, exp);
    endtask
    // Fixed window covers the whole timed operation plus margin
    task automatic run_op(input logic [31:0] c, input logic busy);
        int n;
        int hi;
        hi = 0;
        // Mode bits must stand before the key; the start write may not break it
        i_cpu_core_model.wr(CONTROL_OFS, c);
        i_cpu_core_model.unlock(c);
        for (n = 0; n < P + 30; n++) begin
            @(posedge core_clk_in);
            if (cpu_stall_out === 1'b1) hi++;
        end
        chk({31'h0, hi != 0}, {31'h0, busy});
    endtask
    task automatic check_word(input int j);
        int n;
        logic [13:0] w;
        w = mem[row + j];
        i_cpu_core_model.set_addr(15'(row + j));
        i_cpu_core_model.start_read(perm);
        for (n = 0; n < 20; n++) begin
            i_cpu_core_model.rd(CONTROL_OFS, d, r);
            if (d[READ_BIT] === 1'b0) break;
        end
        if (n == 20) fail_now();
        rdchk(DATA_LOW_OFS, {24'h0, w[7:0]});
        rdchk(DATA_HIGH_OFS, {26'h0, w[13:8]});
    endtask
    initial begin
        seed = 52;
        {reset_in, abort_reset_in, code_protect_n_in, bulk_erase_in} = 4'b1010;
        {ext_read_req_in, ext_addr_in, self_program_lock_in} = {1'b0, 15'h0, 2'h3};
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        rdchk(CONTROL_OFS, 32'h0);
        i_cpu_core_model.wr(KEY_OFS, 32'h55);
        rdchk(KEY_OFS, 32'h0);
        i_cpu_core_model.rd(8'h20, d, r);
        chk({30'h0, r}, 32'h2);
        i_cpu_core_model.wr(ADDR_HIGH_OFS, 32'hFF);
        rdchk(ADDR_HIGH_OFS, 32'h7F);
        i_cpu_core_model.wr(DATA_HIGH_OFS, 32'hFF);
        rdchk(DATA_HIGH_OFS, 32'h3F);
        row = $random(seed) & 32'h3FF0;
        perm = 32'h0;
        i_cpu_core_model.set_addr(15'(row));
        run_op(ERS, 1'b0);
        perm = PRM;
        i_cpu_core_model.wr(CONTROL_OFS, perm);
        run_op(perm | ERS, 1'b1);
        for (i = 0; i < 16; i++) mem[row + i] = ERASED_WORD;
        for (i = 0; i < 16; i++) lat[i] = ERASED_WORD;
        for (k = 0; k < 4; k++) begin
            i = (k == 0) ? 0 : (k == 3) ? 15 : ($random(seed) & 32'hF);
            v = 14'($random(seed));
            i_cpu_core_model.set_addr(15'(row + i));
            i_cpu_core_model.wr(DATA_LOW_OFS, {24'h0, v[7:0]});
            i_cpu_core_model.wr(DATA_HIGH_OFS, {26'h0, v[13:8]});
            if (k == 2) begin
                i_cpu_core_model.wr(KEY_OFS, 32'h55);
                i_cpu_core_model.wr(ADDR_LOW_OFS, {24'h0, 4'(i), 4'h0} | 32'(row[7:0]));
                i_cpu_core_model.wr(KEY_OFS, 32'hAA);
                i_cpu_core_model.wr(CONTROL_OFS, perm | LWL | 32'h2);
            end else begin
                run_op(perm | LWL, 1'b0);
                lat[i] = v;
            end
        end
        run_op(perm, 1'b1);
        for (i = 0; i < 16; i++) mem[row + i] = lat[i];
        for (i = 0; i < 16; i++) check_word(i);
        self_program_lock_in <= 2'h0;
        run_op(perm | ERS, 1'b0);
        self_program_lock_in <= 2'h3;
        check_word(0);
        ext_addr_in <= 15'(row);
        ext_read_req_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        chk({18'h0, ext_read_data_out}, {18'h0, mem[row]});
        code_protect_n_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        chk({18'h0, ext_read_data_out}, 32'h0);
        code_protect_n_in <= 1'b1;
        bulk_erase_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        bulk_erase_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        chk({18'h0, ext_read_data_out}, {18'h0, ERASED_WORD});
        for (i = 0; i < 16; i++) mem[row + i] = ERASED_WORD;
        code_protect_n_in <= 1'b0;
        i_cpu_core_model.wr(CONTROL_OFS, perm);
        run_op(perm | ERS, 1'b1);
        i_cpu_core_model.unlock(perm | ERS);
        abort_reset_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        abort_reset_in <= 1'b0;
        repeat (P + 30) @(posedge core_clk_in);
        i_cpu_core_model.rd(CONTROL_OFS, d, r);
        chk({31'h0, d[ABORT_BIT]}, 32'h1);
        reset_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        rdchk(CONTROL_OFS, 32'h0);
        give_verdict();
    end
endmodule
